// ==== serial_port_defines.vh ====
// Constants shared by the serial port flags and receiver design
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// Character size codes
`define CHAR_SIZE_NINE 3'h7
`define CHAR_BITS_BASE 4'h5
`define CHAR_BITS_MAX 4'h9

// Parity mode field
`define PARITY_ENABLE_BIT 1
`define PARITY_ODD_BIT 0

// Transmitter states
`define TX_IDLE 3'h0
`define TX_START 3'h1
`define TX_DATA 3'h2
`define TX_PARITY 3'h3
`define TX_STOP1 3'h4
`define TX_STOP2 3'h5

// Receiver states
`define RX_IDLE 2'h0
`define RX_DATA 2'h1
`define RX_PARITY 2'h2
`define RX_STOP 2'h3

// Receive buffer entry layout
`define ENTRY_WIDTH 12
`define ENTRY_DATA_MSB 8
`define ENTRY_FE_BIT 9
`define ENTRY_PE_BIT 10
`define ENTRY_DOR_BIT 11
`define RX_BUF_DEPTH 2'h2

// Reset values
`define LINE_IDLE 1'b1
`define NINE_ZERO 9'h000
`define ENTRY_ZERO 12'h000
`define COUNT_ZERO 4'h0

`endif

// ==== rx_frame_buffer.v ====
// Two-entry receive buffer holding each character with its status bits
`timescale 1ns/100ps
`include "serial_port_defines.vh"

module rx_frame_buffer (
	input wire i_core_clk,
	input wire i_rstn,
	input wire i_flush,
	input wire i_push,
	input wire [`ENTRY_WIDTH-1:0] i_entry,
	input wire i_pop,
	output wire [`ENTRY_WIDTH-1:0] o_head,
	output wire o_not_empty,
	output wire o_full
);

reg [`ENTRY_WIDTH-1:0] mem [0:1];
reg wr_ptr;
reg rd_ptr;
reg [1:0] count;
wire do_push;
wire do_pop;

assign do_push = i_push & (count != `RX_BUF_DEPTH);
assign do_pop = i_pop & (count != 2'h0);
assign o_not_empty = (count != 2'h0);
assign o_full = (count == `RX_BUF_DEPTH);
// Empty buffer reads as zero so status bits never show stale errors
assign o_head = o_not_empty ? mem[rd_ptr] : `ENTRY_ZERO;

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : entry
		always @(posedge i_core_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				mem[g] <= `ENTRY_ZERO;
			end else if (do_push && (wr_ptr == g)) begin
				mem[g] <= i_entry;
			end
		end
	end
endgenerate

always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		wr_ptr <= 1'b0;
		rd_ptr <= 1'b0;
		count <= 2'h0;
	end else if (i_flush) begin
		wr_ptr <= 1'b0;
		rd_ptr <= 1'b0;
		count <= 2'h0;
	end else begin
		if (do_push) begin
			wr_ptr <= ~wr_ptr;
		end
		if (do_pop) begin
			rd_ptr <= ~rd_ptr;
		end
		if (do_push && !do_pop) begin
			count <= count + 2'h1;
		end else if (do_pop && !do_push) begin
			count <= count - 2'h1;
		end
	end
end

endmodule

// ==== serial_port_flags_and_receiver.v ====
// Serial port transmitter flags, parity insertion and two-entry receiver
`timescale 1ns/100ps
`include "serial_port_defines.vh"

module serial_port_flags_and_receiver (
	input wire i_core_clk,
	input wire i_rstn,
	input wire i_baud_tick,
	input wire i_sync_mode,
	input wire i_transmit_enable,
	input wire i_receive_enable,
	input wire [1:0] i_parity_mode,
	input wire [2:0] i_char_size,
	input wire i_stop_bit_count,
	input wire i_tx_empty_irq_enable,
	input wire i_tx_done_irq_enable,
	input wire i_rx_done_irq_enable,
	input wire i_data_wr,
	input wire [7:0] i_data_wdata,
	input wire i_tx_ninth_bit,
	input wire i_tx_complete_clear,
	input wire i_tx_done_irq_ack,
	input wire i_data_rd,
	input wire i_serial_in_pin,
	input wire i_external_bit_clock_pin,
	output wire o_serial_out_pin,
	output wire o_serial_out_oe,
	output wire o_serial_in_claimed,
	output wire o_tx_buffer_empty,
	output wire o_tx_complete,
	output wire [7:0] o_rx_data,
	output wire o_rx_ninth_bit,
	output wire o_rx_complete,
	output wire o_frame_error,
	output wire o_data_overrun,
	output wire o_parity_error,
	output wire o_tx_empty_irq,
	output wire o_tx_done_irq,
	output wire o_rx_done_irq
);

localparam ST_TX_IDLE = `TX_IDLE;
localparam ST_TX_START = `TX_START;
localparam ST_TX_DATA = `TX_DATA;
localparam ST_TX_PARITY = `TX_PARITY;
localparam ST_TX_STOP1 = `TX_STOP1;
localparam ST_TX_STOP2 = `TX_STOP2;
localparam ST_RX_IDLE = `RX_IDLE;
localparam ST_RX_DATA = `RX_DATA;
localparam ST_RX_PARITY = `RX_PARITY;
localparam ST_RX_STOP = `RX_STOP;

// Pin synchronisers
reg rxd_meta;
reg rxd_sync;
reg xck_meta;
reg xck_sync;
reg xck_last;

always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		rxd_meta <= `LINE_IDLE;
		rxd_sync <= `LINE_IDLE;
		xck_meta <= 1'b0;
		xck_sync <= 1'b0;
		xck_last <= 1'b0;
	end else begin
		rxd_meta <= i_serial_in_pin;
		rxd_sync <= rxd_meta;
		xck_meta <= i_external_bit_clock_pin;
		xck_sync <= xck_meta;
		xck_last <= xck_sync;
	end
end

wire xck_rise;
wire xck_fall;
wire tx_tick;
wire rx_tick;
assign xck_rise = xck_sync & ~xck_last;
assign xck_fall = ~xck_sync & xck_last;
// In sync mode transmit changes on the falling edge, receive samples on the rising one; otherwise both use i_baud_tick
assign tx_tick = i_sync_mode ? xck_fall : i_baud_tick;
assign rx_tick = i_sync_mode ? xck_rise : i_baud_tick;

// Frame format
wire [3:0] char_bits;
wire parity_on;
assign char_bits = (i_char_size == `CHAR_SIZE_NINE) ? `CHAR_BITS_MAX :
	(`CHAR_BITS_BASE + {2'h0, i_char_size[1:0]});
assign parity_on = i_parity_mode[`PARITY_ENABLE_BIT];

// Keep only the active data bits of a nine-bit word
function [8:0] mask_data;
	input [8:0] value;
	input [3:0] bits;
	reg [8:0] m;
	begin
		m = ~(9'h1ff << bits);
		mask_data = value & m;
	end
endfunction

// Transmitter
reg [8:0] hold_data;
reg hold_full;
reg [8:0] tx_shift;
reg [3:0] tx_count;
reg [2:0] tx_state;
reg tx_parity;
reg tx_line;
reg tx_on;
reg tx_complete;
wire tx_busy;
wire tx_load;
wire [8:0] hold_masked;
wire frame_end;

assign tx_busy = (tx_state != ST_TX_IDLE);
assign hold_masked = mask_data(hold_data, char_bits);
assign frame_end = tx_tick & (((tx_state == ST_TX_STOP1) & ~i_stop_bit_count) |
	(tx_state == ST_TX_STOP2));
// Holding buffer moves to the shifter when idle or right after the last stop bit
assign tx_load = tx_tick & hold_full & tx_on &
	((tx_state == ST_TX_IDLE) | frame_end);

always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		hold_data <= `NINE_ZERO;
		hold_full <= 1'b0;
	end else begin
		if (tx_load) begin
			hold_full <= 1'b0;
		end
		if (i_data_wr) begin
			hold_data <= {i_tx_ninth_bit, i_data_wdata};
			hold_full <= 1'b1;
		end
	end
end

always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		tx_shift <= `NINE_ZERO;
		tx_count <= `COUNT_ZERO;
		tx_state <= ST_TX_IDLE;
		tx_parity <= 1'b0;
		tx_line <= `LINE_IDLE;
	end else if (tx_load) begin
		tx_shift <= hold_masked;
		tx_parity <= (^hold_masked) ^ i_parity_mode[`PARITY_ODD_BIT];
		tx_count <= `COUNT_ZERO;
		tx_line <= 1'b0;
		tx_state <= ST_TX_START;
	end else if (tx_tick) begin
		case (tx_state)
			ST_TX_START: begin
				tx_line <= tx_shift[0];
				tx_shift <= {1'b0, tx_shift[8:1]};
				tx_count <= 4'h1;
				tx_state <= ST_TX_DATA;
			end
			ST_TX_DATA: begin
				if (tx_count == char_bits) begin
					if (parity_on) begin
						tx_line <= tx_parity;
						tx_state <= ST_TX_PARITY;
					end else begin
						tx_line <= `LINE_IDLE;
						tx_state <= ST_TX_STOP1;
					end
				end else begin
					tx_line <= tx_shift[0];
					tx_shift <= {1'b0, tx_shift[8:1]};
					tx_count <= tx_count + 4'h1;
				end
			end
			ST_TX_PARITY: begin
				tx_line <= `LINE_IDLE;
				tx_state <= ST_TX_STOP1;
			end
			ST_TX_STOP1: begin
				tx_line <= `LINE_IDLE;
				tx_state <= i_stop_bit_count ? ST_TX_STOP2 : ST_TX_IDLE;
			end
			ST_TX_STOP2: begin
				tx_line <= `LINE_IDLE;
				tx_state <= ST_TX_IDLE;
			end
			default: begin
				tx_line <= `LINE_IDLE;
				tx_state <= ST_TX_IDLE;
			end
		endcase
	end
end

// Transmitter stays on after disable until nothing is left to send
always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		tx_on <= 1'b0;
	end else if (i_transmit_enable) begin
		tx_on <= 1'b1;
	end else if (!tx_busy && !hold_full && !i_data_wr) begin
		tx_on <= 1'b0;
	end
end

// Set wins over either clear so a finishing frame is never missed
always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		tx_complete <= 1'b0;
	end else if (frame_end && !hold_full) begin
		tx_complete <= 1'b1;
	end else if (i_tx_complete_clear || i_tx_done_irq_ack) begin
		tx_complete <= 1'b0;
	end
end

assign o_serial_out_pin = tx_on ? tx_line : `LINE_IDLE;
assign o_serial_out_oe = tx_on;
assign o_tx_buffer_empty = ~hold_full;
assign o_tx_complete = tx_complete;

// Receiver
reg [1:0] rx_state;
reg [8:0] rx_shift;
reg [3:0] rx_count;
reg rx_pbit;
reg rx_wait;
reg [8:0] wait_data;
reg wait_fe;
reg wait_pe;
reg dor_pending;
wire [8:0] rx_aligned;
wire rx_calc_parity;
wire buf_full;
wire buf_not_empty;
wire buf_push;
wire [`ENTRY_WIDTH-1:0] buf_head;

// Bits arrive LSB first into the top, so shift down by the unused count
assign rx_aligned = rx_shift >> (`CHAR_BITS_MAX - char_bits);
assign rx_calc_parity = (^rx_aligned) ^ i_parity_mode[`PARITY_ODD_BIT];
assign buf_push = rx_wait & ~buf_full;
assign o_serial_in_claimed = i_receive_enable;

always @(posedge i_core_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		rx_state <= ST_RX_IDLE;
		rx_shift <= `NINE_ZERO;
		rx_count <= `COUNT_ZERO;
		rx_pbit <= 1'b0;
		rx_wait <= 1'b0;
		wait_data <= `NINE_ZERO;
		wait_fe <= 1'b0;
		wait_pe <= 1'b0;
		dor_pending <= 1'b0;
	end else if (!i_receive_enable) begin
		// Disable is immediate; a frame in flight is dropped
		rx_state <= ST_RX_IDLE;
		rx_wait <= 1'b0;
		dor_pending <= 1'b0;
	end else begin
		if (buf_push) begin
			rx_wait <= 1'b0;
			dor_pending <= 1'b0;
		end
		if (rx_tick) begin
			case (rx_state)
				ST_RX_IDLE: begin
					if (!rxd_sync) begin
						rx_count <= `COUNT_ZERO;
						rx_shift <= `NINE_ZERO;
						rx_state <= ST_RX_DATA;
						if (rx_wait && buf_full) begin
							dor_pending <= 1'b1;
						end
					end
				end
				ST_RX_DATA: begin
					rx_shift <= {rxd_sync, rx_shift[8:1]};
					rx_count <= rx_count + 4'h1;
					if (rx_count == char_bits - 4'h1) begin
						rx_state <= parity_on ? ST_RX_PARITY : ST_RX_STOP;
					end
				end
				ST_RX_PARITY: begin
					rx_pbit <= rxd_sync;
					rx_state <= ST_RX_STOP;
				end
				ST_RX_STOP: begin
					// Only the first stop bit is looked at; idle skips a second
					wait_data <= rx_aligned;
					wait_fe <= ~rxd_sync;
					wait_pe <= parity_on & (rx_calc_parity != rx_pbit);
					rx_wait <= 1'b1;
					rx_state <= ST_RX_IDLE;
				end
				default: begin
					rx_state <= ST_RX_IDLE;
				end
			endcase
		end
	end
end

rx_frame_buffer rx_frame_buffer_inst (
	.i_core_clk(i_core_clk),
	.i_rstn(i_rstn),
	.i_flush(~i_receive_enable),
	.i_push(buf_push),
	.i_entry({dor_pending, wait_pe, wait_fe, wait_data}),
	.i_pop(i_data_rd),
	.o_head(buf_head),
	.o_not_empty(buf_not_empty),
	.o_full(buf_full)
);

// Status is read from the buffer head only; no write path exists
assign o_rx_data = buf_head[7:0];
assign o_rx_ninth_bit = buf_head[`ENTRY_DATA_MSB];
assign o_frame_error = buf_head[`ENTRY_FE_BIT];
// Gated so a stored error reads zero once checking is switched off
assign o_parity_error = buf_head[`ENTRY_PE_BIT] & parity_on;
assign o_data_overrun = buf_head[`ENTRY_DOR_BIT];
assign o_rx_complete = buf_not_empty;

// Interrupt levels; global masking lives outside
assign o_tx_empty_irq = ~hold_full & i_tx_empty_irq_enable;
assign o_tx_done_irq = tx_complete & i_tx_done_irq_enable;
assign o_rx_done_irq = buf_not_empty & i_rx_done_irq_enable;

endmodule

// ==== serial_port_flags_and_receiver_checker.sv ====
// Port-level assertions for the serial port flags and receiver
`timescale 1ns/100ps
module serial_port_flags_and_receiver_checker (
	input wire i_core_clk,
	input wire i_rstn,
	input wire i_receive_enable,
	input wire [1:0] i_parity_mode,
	input wire [2:0] i_char_size,
	input wire i_tx_empty_irq_enable,
	input wire i_tx_done_irq_enable,
	input wire i_rx_done_irq_enable,
	input wire i_data_wr,
	input wire i_tx_complete_clear,
	input wire i_tx_done_irq_ack,
	input wire o_serial_in_claimed,
	input wire o_tx_buffer_empty,
	input wire o_tx_complete,
	input wire [7:0] o_rx_data,
	input wire o_rx_complete,
	input wire o_frame_error,
	input wire o_data_overrun,
	input wire o_parity_error,
	input wire o_tx_empty_irq,
	input wire o_tx_done_irq,
	input wire o_rx_done_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_service;
		o_tx_complete && (i_tx_done_irq_ack || i_tx_complete_clear);
	endsequence
	a_empty_irq_level: assert property (o_tx_empty_irq == (o_tx_buffer_empty &&
		i_tx_empty_irq_enable)) else $error("empty irq level wrong");
	a_done_irq_level: assert property (o_tx_done_irq == (o_tx_complete &&
		i_tx_done_irq_enable)) else $error("done irq level wrong");
	a_rx_irq_level: assert property (o_rx_done_irq == (o_rx_complete &&
		i_rx_done_irq_enable)) else $error("rx irq level wrong");
	a_write_clears_empty: assert property (i_data_wr |=> !o_tx_buffer_empty)
		else $error("write left buffer empty");
	a_service_clears_done: assert property (s_service |=> !o_tx_complete)
		else $error("tx complete not cleared");
	a_done_after_empty: assert property ($rose(o_tx_complete) |-> o_tx_buffer_empty)
		else $error("tx complete with data waiting");
	a_flush_on_disable: assert property (!i_receive_enable |=> !o_rx_complete)
		else $error("buffer not flushed");
	a_empty_reads_zero: assert property (!o_rx_complete |-> o_rx_data == 8'h00 &&
		!o_frame_error && !o_data_overrun && !o_parity_error) else $error("empty head not zero");
	a_short_upper_zero: assert property (o_rx_complete && i_char_size == 3'h0 |->
		o_rx_data[7:5] == 3'h0) else $error("upper bits not zero");
	a_parity_off_zero: assert property (!i_parity_mode[1] |-> !o_parity_error)
		else $error("parity error while off");
	a_claim_follows: assert property (o_serial_in_claimed == i_receive_enable)
		else $error("pin claim wrong");
endmodule

// ==== serial_line_partner.sv ====
// Remote serial transmitter model driving the receive pin
`timescale 1ns/100ps
module serial_line_partner (
	input wire i_core_clk,
	input wire i_baud_tick,
	output reg o_line
);
	integer i;
	reg p;
	initial o_line = 1'b1;
	task bit_time(input b);
		begin
			@(posedge i_core_clk);
			while (!i_baud_tick) @(posedge i_core_clk);
			#2 o_line = b;
		end
	endtask
	// Idle bit after stop so a bad stop is not taken as a start
	task send(input [8:0] d, input [3:0] n, input [1:0] pm, input bad_par, input stop);
		begin
			p = pm[0] ^ bad_par;
			bit_time(1'b0);
			for (i = 0; i < n; i = i + 1) begin
				bit_time(d[i]);
				p = p ^ d[i];
			end
			if (pm[1])
				bit_time(p);
			bit_time(stop);
			bit_time(1'b1);
		end
	endtask
endmodule

// ==== tb_serial_port_flags_and_receiver.sv ====
// Self-checking bench for the serial port flags and receiver
`timescale 1ns/100ps
module tb_serial_port_flags_and_receiver;
	reg i_core_clk, i_rstn, i_baud_tick, i_sync_mode, i_external_bit_clock_pin;
	reg i_transmit_enable, i_receive_enable, i_stop_bit_count, i_tx_ninth_bit;
	reg [1:0] i_parity_mode;
	reg [2:0] i_char_size;
	reg [7:0] i_data_wdata;
	reg i_tx_empty_irq_enable, i_tx_done_irq_enable, i_rx_done_irq_enable;
	reg i_data_wr, i_tx_complete_clear, i_tx_done_irq_ack, i_data_rd;
	wire i_serial_in_pin, o_serial_out_pin, o_serial_out_oe, o_serial_in_claimed;
	wire o_tx_buffer_empty, o_tx_complete, o_rx_ninth_bit, o_rx_complete;
	wire [7:0] o_rx_data;
	wire o_frame_error, o_data_overrun, o_parity_error;
	wire o_tx_empty_irq, o_tx_done_irq, o_rx_done_irq;
	integer num_errors, samples_checked, i;
	reg [2:0] tick_count;
	reg [10:0] cap;

	serial_port_flags_and_receiver serial_port_flags_and_receiver_inst (.*);
	serial_line_partner serial_line_partner_inst (.i_core_clk(i_core_clk),
		.i_baud_tick(i_baud_tick), .o_line(i_serial_in_pin));

	always #25 i_core_clk = ~i_core_clk;
	// Bit period of eight core clocks keeps frames short
	always @(posedge i_core_clk) begin
		#2 tick_count = tick_count + 3'h1;
		i_baud_tick = (tick_count == 3'h7);
		// External bit clock falls with each bit change, rises mid-bit
		i_external_bit_clock_pin = tick_count[2];
	end

	task complete_run;
		begin
			if (num_errors == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task cmp(input [8*8:1] nm, input [10:0] exp, input [10:0] got);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("unexpected %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task step;
		begin
			@(posedge i_core_clk);
			#2;
		end
	endtask
	task at_tick;
		begin
			@(posedge i_core_clk);
			while (!i_baud_tick) @(posedge i_core_clk);
			#2;
		end
	endtask
	task pulse_wr(input [7:0] d);
		begin
			i_data_wdata = d;
			i_data_wr = 1'b1;
			step;
			i_data_wr = 1'b0;
		end
	endtask
	// Status first: the read moves the head on
	task pop(input [8:0] d, input [2:0] fl);
		begin
			cmp("data", {2'b00, d}, {2'b00, o_rx_ninth_bit, o_rx_data});
			cmp("flags", {8'h00, fl}, {8'h00, o_data_overrun, o_frame_error, o_parity_error});
			i_data_rd = 1'b1;
			step;
			i_data_rd = 1'b0;
			step;
		end
	endtask
	task rx_case(input [2:0] cs, input [1:0] pm, input [8:0] d, input bp, input sb,
		input [2:0] fl);
		begin
			i_char_size = cs;
			i_parity_mode = pm;
			serial_line_partner_inst.send(d, (cs == 3'h7) ? 4'h9 : {1'b0, cs} + 4'h5, pm, bp, sb);
			repeat (3) step;
			cmp("rxc", 11'h001, {10'h000, o_rx_complete});
			pop(d, fl);
		end
	endtask
	task tx_frame(input [10:0] exp);
		begin
			at_tick;
			while (o_serial_out_pin !== 1'b0) at_tick;
			cap = 11'h000;
			for (i = 0; i < 10; i = i + 1) begin
				at_tick;
				cap = {o_serial_out_pin, cap[10:1]};
			end
			cmp("frame", exp, cap);
		end
	endtask

	initial begin
		#1000000;
		num_errors = num_errors + 1;
		complete_run;
	end

	initial begin
		num_errors = 0;
		samples_checked = 0;
		tick_count = 3'h0;
		{i_core_clk, i_rstn, i_baud_tick, i_sync_mode, i_external_bit_clock_pin} = 5'h00;
		{i_transmit_enable, i_receive_enable, i_stop_bit_count, i_tx_ninth_bit} = 4'h0;
		{i_tx_empty_irq_enable, i_tx_done_irq_enable, i_rx_done_irq_enable} = 3'h7;
		{i_data_wr, i_tx_complete_clear, i_tx_done_irq_ack, i_data_rd} = 4'h0;
		i_parity_mode = 2'h0;
		i_char_size = 3'h3;
		i_data_wdata = 8'h00;
		repeat (6) @(posedge i_core_clk);
		#2 i_rstn = 1'b1;
		cmp("idle", 11'h012, {6'h00, o_tx_buffer_empty, o_tx_complete, o_serial_out_oe,
			o_serial_out_pin, o_rx_complete});
		i_receive_enable = 1'b1;
		repeat (2) step;
		rx_case(3'h3, 2'h0, 9'h0a5, 1'b0, 1'b1, 3'h0);
		rx_case(3'h3, 2'h2, 9'h0c3, 1'b0, 1'b1, 3'h0);
		rx_case(3'h3, 2'h3, 9'h0c3, 1'b1, 1'b1, 3'h1);
		rx_case(3'h3, 2'h2, 9'h017, 1'b1, 1'b1, 3'h1);
		rx_case(3'h0, 2'h0, 9'h015, 1'b0, 1'b1, 3'h0);
		rx_case(3'h7, 2'h0, 9'h13c, 1'b0, 1'b1, 3'h0);
		i_sync_mode = 1'b1;
		rx_case(3'h3, 2'h3, 9'h05a, 1'b0, 1'b1, 3'h0);
		i_sync_mode = 1'b0;
		i_stop_bit_count = 1'b1;
		rx_case(3'h3, 2'h0, 9'h081, 1'b0, 1'b0, 3'h2);
		rx_case(3'h3, 2'h0, 9'h07e, 1'b0, 1'b1, 3'h0);
		i_stop_bit_count = 1'b0;
		for (i = 1; i < 5; i = i + 1)
			serial_line_partner_inst.send(i[8:0], 4'h8, 2'h0, 1'b0, 1'b1);
		repeat (3) step;
		pop(9'h001, 3'h0);
		pop(9'h002, 3'h0);
		pop(9'h004, 3'h4);
		cmp("rxc", 11'h000, {10'h000, o_rx_complete});
		serial_line_partner_inst.send(9'h055, 4'h8, 2'h0, 1'b0, 1'b1);
		repeat (3) step;
		cmp("held", 11'h001, {10'h000, o_rx_complete});
		i_receive_enable = 1'b0;
		step;
		cmp("flush", 11'h000, {10'h000, o_rx_complete});
		i_parity_mode = 2'h2;
		i_transmit_enable = 1'b1;
		step;
		pulse_wr(8'h5b);
		cmp("empty", 11'h000, {10'h000, o_tx_buffer_empty});
		tx_frame(11'h6b6);
		at_tick;
		repeat (2) step;
		cmp("txc", 11'h003, {9'h000, o_tx_complete, o_tx_done_irq});
		i_tx_done_irq_ack = 1'b1;
		step;
		i_tx_done_irq_ack = 1'b0;
		cmp("ack", 11'h000, {10'h000, o_tx_complete});
		i_tx_empty_irq_enable = 1'b0;
		fork
			begin
				tx_frame(11'h41e);
				tx_frame(11'h700);
			end
			begin
				pulse_wr(8'h0f);
				while (o_tx_buffer_empty !== 1'b1) step;
				pulse_wr(8'h80);
				cmp("empty", 11'h000, {10'h000, o_tx_buffer_empty});
				i_transmit_enable = 1'b0;
			end
		join
		at_tick;
		repeat (2) step;
		cmp("release", 11'h003, {8'h00, o_serial_out_oe, o_serial_out_pin, o_tx_complete});
		// Only i_tx_complete_clear is pulsed; no other input changes with it
		i_tx_complete_clear = 1'b1;
		step;
		i_tx_complete_clear = 1'b0;
		cmp("clear", 11'h000, {10'h000, o_tx_complete});
		complete_run;
	end
endmodule

bind serial_port_flags_and_receiver serial_port_flags_and_receiver_checker
	serial_port_flags_and_receiver_checker_inst (.*);
